// ### shared/rspd_defines.vh
// timing constants and reset values of the rs232 powerdown control
`ifndef RSPD_DEFINES_VH
`define RSPD_DEFINES_VH

`define RSPD_CLK_MHZ 250
// inactivity time before automatic powerdown, in seconds
`define RSPD_IDLE_S 30
// invalid-level time before signal-absent goes low, in microseconds
`define RSPD_INVALID_US 30
// valid-level time before signal-absent releases, in microseconds
`define RSPD_VALID_US 1
// time allowed to resume transmission, in microseconds
`define RSPD_WAKE_US 100
// cycle counts derived from the rate
// idle count exceeds 32 bits, so the product is formed at 40 bits
`define RSPD_IDLE_CYC (`RSPD_IDLE_S * 40'h00000F4240 * `RSPD_CLK_MHZ)
`define RSPD_INVALID_CYC (`RSPD_INVALID_US * `RSPD_CLK_MHZ + 1)
`define RSPD_VALID_CYC (`RSPD_VALID_US * `RSPD_CLK_MHZ)
`define RSPD_WAKE_CYC (`RSPD_WAKE_US * `RSPD_CLK_MHZ)
// reset values
`define RSPD_RST_TIMED_OUT 1'b1
`define RSPD_RST_ABSENT_N 1'b0

`endif

// ### core/rspd_edge_detect.v
// synchroniser and change detector for the line inputs
`timescale 1ns/1ns
module rspd_edge_detect #(
    parameter WIDTH = 8
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire [WIDTH-1:0] i_lines,
    output wire o_activity
);
    reg [WIDTH-1:0] sync1;
    reg [WIDTH-1:0] sync2;
    reg [WIDTH-1:0] last;
    reg [2:0] fill;

    // two-stage sync then a compare against the previous sample
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1 <= {WIDTH{1'b0}};
            sync2 <= {WIDTH{1'b0}};
            last <= {WIDTH{1'b0}};
            fill <= 3'h0;
        end else begin
            sync1 <= i_lines;
            sync2 <= sync1;
            last <= sync2;
            fill <= {fill[1:0], 1'b1};
        end
    end

    // silent until sync and compare stages hold real samples
    assign o_activity = fill[2] && (sync2 != last);
endmodule // rspd_edge_detect

// ### core/rspd_valid_detect.v
// signal-absent detector over the receiver level-valid inputs
`timescale 1ns/1ns
`include "rspd_defines.vh"
module rspd_valid_detect #(
    parameter NRX = 5,
    parameter INVALID_CYC = `RSPD_INVALID_CYC,
    parameter VALID_CYC = `RSPD_VALID_CYC
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire [NRX-1:0] i_level_valid,
    output reg o_signal_absent_n
);
    localparam CW = 16;
    reg [CW-1:0] count;
    wire any_valid;

    // floating inputs report not-valid, so they count as invalid
    assign any_valid = |i_level_valid;

    // count the present condition against the flag's opposite state
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= {CW{1'b0}};
            o_signal_absent_n <= `RSPD_RST_ABSENT_N;
        end else if (o_signal_absent_n && !any_valid) begin
            // all invalid for more than the invalid time
            if (count >= INVALID_CYC[CW-1:0] - 16'h0001) begin
                o_signal_absent_n <= 1'b0;
                count <= {CW{1'b0}};
            end else begin
                count <= count + 16'h0001;
            end
        end else if (!o_signal_absent_n && any_valid) begin
            // valid level seen, release after the valid delay
            if (count >= VALID_CYC[CW-1:0] - 16'h0001) begin
                o_signal_absent_n <= 1'b1;
                count <= {CW{1'b0}};
            end else begin
                count <= count + 16'h0001;
            end
        end else begin
            count <= {CW{1'b0}};
        end
    end
endmodule // rspd_valid_detect

// ### core/rspd_control.v
// power state control of a multi-channel rs232 transceiver
//
// How it works
// - force-sleep low forces powerdown, overriding hold-awake
// - hold-awake high disables automatic powerdown; manual still works
// - no line edge for idle time shuts pump and transmitters off
// - any line edge wakes the device from automatic powerdown
// - after any powerdown with hold-awake low the idle timer stays expired until woken
// - with hold-awake low, force-sleep rising alone does not wake
// - hold-awake falling edge restarts a full idle period
// - powerdown disables the pump and floats all transmitters
// - inverting receivers float in forced powerdown
// - transmission resumes within the wake time after leaving powerdown
// - signal-absent goes low after all receivers invalid over 30 us
// - signal-absent releases 1 us after any valid receiver level
// - signal-absent detector runs always and never alters power state
// - floating receiver inputs count as invalid levels
// - hybrid scheme stays down until valid levels and a line edge
// - ready drops on powerdown, rises once negative rail reaches -4 V
// - inverting receivers stay active during automatic powerdown
// - monitor receiver output stays active in every mode
`timescale 1ns/1ns
`include "rspd_defines.vh"
module rspd_control #(
    parameter NTX = 3,
    parameter NRX = 5,
    parameter [39:0] IDLE_CYC = `RSPD_IDLE_CYC,
    parameter INVALID_CYC = `RSPD_INVALID_CYC,
    parameter VALID_CYC = `RSPD_VALID_CYC,
    parameter WAKE_CYC = `RSPD_WAKE_CYC
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_hold_awake_input,
    input wire i_force_sleep_input_n,
    input wire [NTX-1:0] i_tx_in,
    input wire [NRX-1:0] i_rx_in,
    input wire [NRX-1:0] i_rx_level_valid,
    input wire i_neg_rail_ok,
    output reg o_pump_en,
    output reg o_tx_oe,
    output reg o_rx_oe,
    output wire o_monitor_receiver_output_oe,
    output wire o_signal_absent_n,
    output reg o_ready,
    output reg o_wake_late
);
    ////////////////////////////////////////////////////////////////////
    // state and counters
    localparam ST_ON = 2'b00;
    localparam ST_AUTO_DOWN = 2'b01;
    localparam ST_FORCED_DOWN = 2'b10;
    localparam TW = 40;
    localparam WW = 20;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [TW-1:0] idle_count;
    reg timed_out;
    reg hold_awake_d;
    reg [WW-1:0] wake_count;
    wire activity;
    wire hold_fall;
    wire down;

    ////////////////////////////////////////////////////////////////////
    // helpers
    rspd_edge_detect #(
        .WIDTH(NTX + NRX)
    ) u_edges (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_lines({i_tx_in, i_rx_in}),
        .o_activity(activity)
    );

    // detector is free-running and only reported, not fed back
    rspd_valid_detect #(
        .NRX(NRX),
        .INVALID_CYC(INVALID_CYC),
        .VALID_CYC(VALID_CYC)
    ) u_valid (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_level_valid(i_rx_level_valid),
        .o_signal_absent_n(o_signal_absent_n)
    );

    ////////////////////////////////////////////////////////////////////
    // inactivity timer
    assign hold_fall = hold_awake_d && !i_hold_awake_input;
    assign down = (state != ST_ON);

    // expired flag holds while down; edge or hold-awake clears it
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            idle_count <= {TW{1'b0}};
            timed_out <= `RSPD_RST_TIMED_OUT;
            hold_awake_d <= 1'b0;
        end else begin
            hold_awake_d <= i_hold_awake_input;
            if (activity || i_hold_awake_input || hold_fall) begin
                idle_count <= {TW{1'b0}};
                timed_out <= 1'b0;
            end else if (!i_force_sleep_input_n) begin
                timed_out <= 1'b1;
                idle_count <= {TW{1'b0}};
            end else if (!timed_out) begin
                if (idle_count >= IDLE_CYC[TW-1:0] - 40'h0000000001) begin
                    timed_out <= 1'b1;
                end else begin
                    idle_count <= idle_count + 40'h0000000001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power state machine
    always @* begin
        next_state = state;
        case (state)
            ST_ON: begin
                if (!i_force_sleep_input_n) begin
                    next_state = ST_FORCED_DOWN;
                end else if (timed_out && !i_hold_awake_input) begin
                    next_state = ST_AUTO_DOWN;
                end
            end
            ST_AUTO_DOWN, ST_FORCED_DOWN: begin
                if (!i_force_sleep_input_n) begin
                    next_state = ST_FORCED_DOWN;
                end else if (!timed_out || i_hold_awake_input) begin
                    // force-sleep rising alone leaves timer expired
                    next_state = ST_ON;
                end
            end
            default: begin
                next_state = ST_FORCED_DOWN;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_FORCED_DOWN;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output enables and ready
    assign o_monitor_receiver_output_oe = 1'b1;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pump_en <= 1'b0;
            o_tx_oe <= 1'b0;
            o_rx_oe <= 1'b0;
            o_ready <= 1'b0;
            wake_count <= {WW{1'b0}};
            o_wake_late <= 1'b0;
        end else begin
            o_pump_en <= (next_state == ST_ON);
            // transmitters enable only once the rail is up
            o_tx_oe <= (next_state == ST_ON) && i_neg_rail_ok;
            o_rx_oe <= (next_state != ST_FORCED_DOWN);
            o_ready <= (next_state == ST_ON) && i_neg_rail_ok;
            // watch the rail-up time against the wake limit
            if (down || o_ready) begin
                wake_count <= {WW{1'b0}};
                o_wake_late <= 1'b0;
            end else if (wake_count >= WAKE_CYC[WW-1:0]) begin
                o_wake_late <= 1'b1;
            end else begin
                wake_count <= wake_count + 20'h00001;
            end
        end
    end
endmodule // rspd_control

// ### test/rspd_host_model.sv
// host power logic and negative pump rail model
`timescale 1ns/1ns
module rspd_host_model #(
    parameter RAIL_DLY = 20
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_pump_en,
    input wire i_signal_absent_n,
    input wire i_loop,
    input wire i_hold,
    input wire i_sleep_n,
    output wire o_hold_awake_input,
    output wire o_force_sleep_input_n,
    output wire o_neg_rail_ok
);
reg [7:0] rail_cnt;
////////////////////////////////////////
// rail charges while the pump runs, collapses at once when it stops
always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n)
        rail_cnt <= 8'h00;
    else if (!i_pump_en)
        rail_cnt <= 8'h00;
    else if (rail_cnt != RAIL_DLY)
        rail_cnt <= rail_cnt + 8'h01;
end
assign o_neg_rail_ok = (rail_cnt == RAIL_DLY);
// loop-back of signal-absent; hold low keeps hold-awake low (hybrid)
assign o_hold_awake_input = i_loop ? (i_signal_absent_n & i_hold)
    : i_hold;
assign o_force_sleep_input_n = i_loop ? i_signal_absent_n : i_sleep_n;
endmodule // rspd_host_model

// ### test/rspd_control_properties.sv
// port assertions of the rs232 powerdown control
`timescale 1ns/1ns
module rspd_checker #(
    parameter NRX = 5,
    parameter INVALID_CYC = 50,
    parameter VALID_CYC = 10
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_hold_awake_input,
    input wire i_force_sleep_input_n,
    input wire [NRX-1:0] i_rx_level_valid,
    input wire o_pump_en,
    input wire o_tx_oe,
    input wire o_rx_oe,
    input wire o_monitor_receiver_output_oe,
    input wire o_signal_absent_n,
    input wire o_ready
);
localparam int WAKE_MAX = 100;
reg [15:0] inv_cnt;
reg [15:0] val_cnt;
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_arst_n);
////////////////////////////////////////
// run lengths of all-invalid and any-valid receiver levels
always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        inv_cnt <= 16'h0000;
        val_cnt <= 16'h0000;
    end else if (|i_rx_level_valid) begin
        inv_cnt <= 16'h0000;
        val_cnt <= val_cnt + {15'h0000, ~&val_cnt};
    end else begin
        val_cnt <= 16'h0000;
        inv_cnt <= inv_cnt + {15'h0000, ~&inv_cnt};
    end
end
sequence s_pins_on;
    i_hold_awake_input && i_force_sleep_input_n;
endsequence
sequence s_pump_up;
    $rose(o_pump_en);
endsequence
sleep_off_a: assert property (!i_force_sleep_input_n |=> !o_pump_en)
    else $error("pump on while forced asleep");
rx_float_a: assert property (!i_force_sleep_input_n |=> !o_rx_oe)
    else $error("receivers driven in forced sleep");
rx_auto_a: assert property (i_force_sleep_input_n [*3] ##0
    $fell(o_pump_en) |-> o_rx_oe) else $error("receivers off in auto");
monitor_on_a: assert property (o_monitor_receiver_output_oe)
    else $error("monitor receiver disabled");
tx_pump_a: assert property (o_tx_oe |-> o_pump_en)
    else $error("transmitters on without pump");
ready_pump_a: assert property (o_ready |-> o_pump_en)
    else $error("ready without pump");
pins_on_a: assert property (s_pins_on [*3] |-> o_pump_en)
    else $error("pump off with both pins high");
wake_ready_a: assert property (s_pump_up |->
    ##[1:WAKE_MAX] (o_ready || !o_pump_en)) else $error("wake too slow");
absent_fall_a: assert property ($fell(o_signal_absent_n) |->
    inv_cnt >= INVALID_CYC) else $error("absent flag too early");
absent_low_a: assert property (inv_cnt == INVALID_CYC + 4 |->
    !o_signal_absent_n) else $error("absent flag too late");
absent_high_a: assert property (val_cnt == VALID_CYC + 4 |->
    o_signal_absent_n) else $error("absent flag not released");
endmodule // rspd_checker
bind rspd_control rspd_checker #(.NRX(NRX), .INVALID_CYC(INVALID_CYC),
    .VALID_CYC(VALID_CYC)) u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_hold_awake_input(i_hold_awake_input),
    .i_force_sleep_input_n(i_force_sleep_input_n),
    .i_rx_level_valid(i_rx_level_valid), .o_pump_en(o_pump_en),
    .o_tx_oe(o_tx_oe), .o_rx_oe(o_rx_oe), .o_ready(o_ready),
    .o_monitor_receiver_output_oe(o_monitor_receiver_output_oe),
    .o_signal_absent_n(o_signal_absent_n));

// ### test/tb.sv
// self-checking bench of the rs232 powerdown control
`timescale 1ns/1ns
module tb;
localparam IDLE = 200;
localparam INV = 50;
localparam VAL = 10;
reg clk = 1'b0;
reg arst_n = 1'b0;
reg hold = 1'b1;
reg sleep_n = 1'b0;
reg loop = 1'b0;
reg [2:0] tx = 3'h0;
reg [4:0] rx = 5'h00;
reg [4:0] lvl = 5'h00;
wire hold_pin, sleep_pin_n, rail_ok, pump, tx_oe, rx_oe, mon_oe;
wire absent_n, ready, wake_late;
integer mismatches = 0;
integer checks_done = 0;
integer cyc_cnt = 0;
always #2 clk = ~clk;
rspd_control #(.IDLE_CYC(IDLE), .INVALID_CYC(INV), .VALID_CYC(VAL),
    .WAKE_CYC(100)) uut (.i_clk(clk), .i_arst_n(arst_n),
    .i_hold_awake_input(hold_pin), .i_force_sleep_input_n(sleep_pin_n),
    .i_tx_in(tx), .i_rx_in(rx), .i_rx_level_valid(lvl),
    .i_neg_rail_ok(rail_ok), .o_pump_en(pump), .o_tx_oe(tx_oe),
    .o_rx_oe(rx_oe), .o_monitor_receiver_output_oe(mon_oe),
    .o_signal_absent_n(absent_n), .o_ready(ready),
    .o_wake_late(wake_late));
rspd_host_model host (.i_clk(clk), .i_arst_n(arst_n), .i_pump_en(pump),
    .i_signal_absent_n(absent_n), .i_loop(loop), .i_hold(hold),
    .i_sleep_n(sleep_n), .o_hold_awake_input(hold_pin),
    .o_force_sleep_input_n(sleep_pin_n), .o_neg_rail_ok(rail_ok));
////////////////////////////////////////
task cyc(input integer n);
    repeat (n) @(negedge clk);
endtask
task pins(input logic h, input logic s);
    hold = h;
    sleep_n = s;
endtask
task chk(input string nm, input logic exp, input logic got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
endtask
task tend(input string nm);
    $display("test %s done", nm);
endtask
task summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
// hang guard
always @(posedge clk) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 2000) begin
        mismatches = mismatches + 1;
        summarize;
    end
end
// main sequence
initial begin
    cyc(2);
    arst_n = 1'b1;
    cyc(4);
    chk("monitor_oe", 1'b1, mon_oe);
    chk("pump_en", 1'b0, pump);
    chk("rx_oe", 1'b0, rx_oe);
    chk("absent_n", 1'b0, absent_n);
    tend("forced");
    pins(1'b1, 1'b1);
    cyc(30);
    chk("tx_oe", 1'b1, tx_oe);
    chk("ready", 1'b1, ready);
    cyc(IDLE + 20);
    chk("pump_en", 1'b1, pump);
    tend("hold awake");
    pins(1'b0, 1'b1);
    cyc(IDLE - 20);
    chk("pump_en", 1'b1, pump);
    cyc(40);
    chk("pump_en", 1'b0, pump);
    chk("tx_oe", 1'b0, tx_oe);
    chk("rx_oe", 1'b1, rx_oe);
    chk("ready", 1'b0, ready);
    rx[2] = ~rx[2];
    cyc(40);
    chk("ready", 1'b1, ready);
    tend("auto");
    pins(1'b0, 1'b0);
    cyc(3);
    chk("pump_en", 1'b0, pump);
    pins(1'b0, 1'b1);
    cyc(30);
    chk("pump_en", 1'b0, pump);
    tx[0] = ~tx[0];
    cyc(10);
    chk("pump_en", 1'b1, pump);
    tend("manual");
    lvl = 5'h04;
    cyc(VAL + 6);
    chk("absent_n", 1'b1, absent_n);
    lvl = 5'h00;
    cyc(INV - 6);
    chk("absent_n", 1'b1, absent_n);
    cyc(12);
    chk("absent_n", 1'b0, absent_n);
    chk("pump_en", 1'b1, pump);
    tend("absent");
    pins(1'b1, 1'b1);
    loop = 1'b1;
    cyc(3);
    chk("pump_en", 1'b0, pump);
    lvl = 5'h10;
    cyc(VAL + 10);
    chk("pump_en", 1'b1, pump);
    tend("loop");
    pins(1'b0, 1'b1);
    lvl = 5'h00;
    cyc(INV + 6);
    chk("pump_en", 1'b0, pump);
    chk("rx_oe", 1'b0, rx_oe);
    lvl = 5'h10;
    cyc(VAL + 10);
    chk("pump_en", 1'b0, pump);
    rx[0] = ~rx[0];
    cyc(10);
    chk("pump_en", 1'b1, pump);
    cyc(30);
    chk("ready", 1'b1, ready);
    chk("wake_late", 1'b0, wake_late);
    tend("hybrid");
    summarize;
end
endmodule // tb
